// ---- design/cbt_core.sv ----
`timescale 1ns/1ps
// instruction timing sequencer with dual data pointers
module cbt_core (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// instruction stream from program memory
	input wire logic [7:0] opcode,
	input wire logic opcode_valid,
	output logic opcode_ready,
	output logic fetch_strobe,
	// accumulator for the indirect jump
	input wire logic [7:0] acc,
	// special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// timer rate option: high selects four clocks per tick
	input wire logic timer_fast,
	// outputs
	output logic cycle_strobe,
	output logic timer_tick,
	output logic instr_done,
	output logic [15:0] active_data_pointer,
	output logic [15:0] jump_target
);
	// ************************************************
	// reset synchroniser
	// ************************************************
	logic rst_meta_reg;
	logic rst_sync_reg;
	// release through two flops, assertion stays asynchronous
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	wire logic rst_ok_n = rst_sync_reg;

	// ************************************************
	// instruction cycle divider
	// ************************************************
	logic [1:0] phase_reg;
	logic [1:0] phase_next;
	// one-cycle enable every four clocks
	always_comb begin
		phase_next = (phase_reg == cbt_pkg::CLKS_PER_CYCLE_M1) ? 2'h0 : phase_reg + 2'h1;
	end
	always_ff @(posedge mclk or negedge rst_ok_n) begin
		if (!rst_ok_n) phase_reg <= 2'h0;
		else phase_reg <= phase_next; // [RULE2]
	end
	assign cycle_strobe = (phase_reg == cbt_pkg::CLKS_PER_CYCLE_M1); // [RULE2]

	// ************************************************
	// timer prescaler
	// ************************************************
	logic [3:0] tdiv_reg;
	logic [3:0] tdiv_next;
	logic [3:0] tlimit;
	always_comb begin
		// slow rate keeps classic timing, fast follows the quicker core
		tlimit = timer_fast ? cbt_pkg::TIMER_FAST_M1 : cbt_pkg::TIMER_SLOW_M1; // [RULE14]
		tdiv_next = (tdiv_reg >= tlimit) ? 4'h0 : tdiv_reg + 4'h1;
	end
	always_ff @(posedge mclk or negedge rst_ok_n) begin
		if (!rst_ok_n) tdiv_reg <= 4'h0;
		else tdiv_reg <= tdiv_next;
	end
	assign timer_tick = (tdiv_reg >= tlimit); // [RULE14]

	// ************************************************
	// special function registers
	// ************************************************
	logic [15:0] ptr_a_reg; // first pointer
	logic [15:0] ptr_a_next;
	logic [15:0] ptr_b_reg; // second pointer
	logic [15:0] ptr_b_next;
	logic sel_reg; // only functional select bit
	logic sel_next;
	logic [7:0] stretch_reg;
	logic [7:0] stretch_next;
	// register writes; the other select bits are dropped
	always_comb begin
		ptr_a_next = ptr_a_reg;
		ptr_b_next = ptr_b_reg;
		sel_next = sel_reg;
		stretch_next = stretch_reg;
		if (sfr_wr) begin
			unique case (sfr_addr)
				cbt_pkg::ADDR_PTR_A_LOW: ptr_a_next[7:0] = sfr_wdata; // [RULE16]
				cbt_pkg::ADDR_PTR_A_HIGH: ptr_a_next[15:8] = sfr_wdata; // [RULE16]
				cbt_pkg::ADDR_PTR_B_LOW: ptr_b_next[7:0] = sfr_wdata; // [RULE17]
				cbt_pkg::ADDR_PTR_B_HIGH: ptr_b_next[15:8] = sfr_wdata; // [RULE17]
				// increment of the location flips bit 0 [RULE20]
				cbt_pkg::ADDR_PTR_SELECT: sel_next = sfr_wdata[cbt_pkg::SEL_BIT]; // [RULE19]
				cbt_pkg::ADDR_STRETCH: stretch_next = sfr_wdata;
				default: sel_next = sel_reg;
			endcase
		end
	end
	always_ff @(posedge mclk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			ptr_a_reg <= {cbt_pkg::RESET_BYTE, cbt_pkg::RESET_BYTE}; // [RULE21]
			ptr_b_reg <= {cbt_pkg::RESET_BYTE, cbt_pkg::RESET_BYTE}; // [RULE21]
			sel_reg <= 1'b0; // [RULE21]
			stretch_reg <= cbt_pkg::STRETCH_RESET;
		end else begin
			ptr_a_reg <= ptr_a_next;
			ptr_b_reg <= ptr_b_next;
			sel_reg <= sel_next;
			stretch_reg <= stretch_next;
		end
	end
	// read mux; unused select bits read zero
	always_comb begin
		unique case (sfr_addr)
			cbt_pkg::ADDR_PTR_A_LOW: sfr_rdata = ptr_a_reg[7:0];
			cbt_pkg::ADDR_PTR_A_HIGH: sfr_rdata = ptr_a_reg[15:8];
			cbt_pkg::ADDR_PTR_B_LOW: sfr_rdata = ptr_b_reg[7:0];
			cbt_pkg::ADDR_PTR_B_HIGH: sfr_rdata = ptr_b_reg[15:8];
			cbt_pkg::ADDR_PTR_SELECT: sfr_rdata = {7'h00, sel_reg}; // [RULE19]
			cbt_pkg::ADDR_STRETCH: sfr_rdata = stretch_reg;
			default: sfr_rdata = cbt_pkg::RESET_BYTE;
		endcase
	end
	// sixteen-bit pointer chosen by the select bit
	assign active_data_pointer = sel_reg ? ptr_b_reg : ptr_a_reg; // [RULE15] [RULE18]

	// ************************************************
	// opcode decode
	// ************************************************
	logic [1:0] dec_bytes;
	logic [2:0] dec_cycles;
	logic dec_xmove;
	logic dec_ptr;
	logic dec_jump;
	cbt_decode u_decode (
		.opcode(opcode),
		.stretch(stretch_reg[2:0]),
		.byte_len(dec_bytes),
		.cycle_cnt(dec_cycles),
		.is_xmove(dec_xmove),
		.uses_ptr(dec_ptr),
		.is_jump(dec_jump)
	);

	// ************************************************
	// execution sequencer
	// ************************************************
	cbt_pkg::cbt_state_t state_reg;
	cbt_pkg::cbt_state_t state_next;
	logic [3:0] left_reg; // instruction cycles still to run
	logic [3:0] left_next;
	logic [15:0] target_reg;
	logic [15:0] target_next;
	logic last_cycle; // final instruction cycle of the running opcode
	// opcode taken only on an instruction cycle boundary
	assign last_cycle = (state_reg == cbt_pkg::CBT_EXEC) && (left_reg == 4'h1);
	// ready on the closing edge too, else every opcode would cost an idle cycle [RULE3]
	assign opcode_ready = cycle_strobe && ((state_reg == cbt_pkg::CBT_FETCH) || last_cycle);
	assign fetch_strobe = opcode_ready && opcode_valid; // [RULE5]
	assign instr_done = last_cycle && cycle_strobe;
	// count cycles per opcode; stretch lengthens external moves
	always_comb begin
		state_next = state_reg;
		left_next = left_reg;
		target_next = target_reg;
		unique case (state_reg)
			cbt_pkg::CBT_FETCH: begin
				// idle until an opcode is taken below
				state_next = cbt_pkg::CBT_FETCH;
			end
			cbt_pkg::CBT_EXEC: begin
				if (cycle_strobe) begin
					left_next = left_reg - 4'h1;
					if (left_reg == 4'h1) state_next = cbt_pkg::CBT_FETCH;
				end
			end
			default: state_next = cbt_pkg::CBT_FETCH;
		endcase
		// a taken opcode overrides the countdown, even on its last edge
		if (fetch_strobe) begin
			state_next = cbt_pkg::CBT_EXEC;
			if (dec_xmove)
				left_next = cbt_pkg::XMOVE_BASE + {1'b0, dec_cycles}; // [RULE1]
			else
				left_next = {1'b0, dec_cycles}; // [RULE3]
			if (dec_ptr && dec_jump)
				target_next = active_data_pointer + {8'h00, acc}; // [RULE10]
		end
	end
	always_ff @(posedge mclk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			state_reg <= cbt_pkg::CBT_FETCH;
			left_reg <= 4'h0;
			target_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			left_reg <= left_next;
			target_reg <= target_next;
		end
	end
	assign jump_target = target_reg;

	// ************************************************
	// checks
	// ************************************************
	logic [2:0] cyc_cnt_reg; // helper: clocks since last strobe
	always_ff @(posedge mclk or negedge rst_ok_n) begin
		if (!rst_ok_n) cyc_cnt_reg <= 3'h0;
		else cyc_cnt_reg <= cycle_strobe ? 3'h0 : cyc_cnt_reg + 3'h1;
	end
	cycle_four_a: assert property (@(posedge mclk) disable iff (!rst_ok_n)
		cycle_strobe |-> ##4 cycle_strobe) else $error("cycle not four clocks"); // [RULE2]
	cycle_gap_a: assert property (@(posedge mclk) disable iff (!rst_ok_n)
		cyc_cnt_reg <= 3'h3) else $error("strobe gap too long"); // [RULE2]
	nop_one_a: assert property (@(posedge mclk) disable iff (!rst_ok_n)
		fetch_strobe && (opcode == cbt_pkg::OP_NOP || opcode == cbt_pkg::OP_RESERVED_NOP)
		|-> ##4 instr_done) else $error("no-op not one cycle"); // [RULE13]
	long_four_a: assert property (@(posedge mclk) disable iff (!rst_ok_n)
		fetch_strobe && (opcode == cbt_pkg::OP_LONG_JUMP || opcode == cbt_pkg::OP_LONG_CALL)
		|-> ##16 instr_done) else $error("long branch not four cycles"); // [RULE7]
	short_three_a: assert property (@(posedge mclk) disable iff (!rst_ok_n)
		fetch_strobe && opcode == cbt_pkg::OP_SHORT_JUMP
		|=> !instr_done [*8] ##4 instr_done) else $error("short jump not three cycles"); // [RULE8]
	xread_len_a: assert property (@(posedge mclk) disable iff (!rst_ok_n)
		fetch_strobe && opcode == cbt_pkg::OP_XREAD_PTR && stretch_reg[2:0] == 3'h0
		|-> ##8 instr_done) else $error("pointer read not two cycles"); // [RULE4]
	xmove_load_a: assert property (@(posedge mclk) disable iff (!rst_ok_n)
		fetch_strobe && dec_xmove
		|=> left_reg == 4'h2 + {1'b0, $past(stretch_reg[2:0])}) else $error("stretch count wrong"); // [RULE1]
	ind_target_a: assert property (@(posedge mclk) disable iff (!rst_ok_n)
		fetch_strobe && opcode == cbt_pkg::OP_INDIRECT_JMP
		|=> jump_target == $past(active_data_pointer) + {8'h00, $past(acc)}) else $error("bad target"); // [RULE10]
	sel_pick_a: assert property (@(posedge mclk) disable iff (!rst_ok_n)
		sfr_wr && sfr_addr == cbt_pkg::ADDR_PTR_SELECT
		|=> active_data_pointer == ($past(sfr_wdata[0]) ? ptr_b_reg : ptr_a_reg)) else $error("select"); // [RULE18]
	range_a: assert property (@(posedge mclk) disable iff (!rst_ok_n)
		fetch_strobe && !dec_xmove |=> left_reg >= 4'h1 && left_reg <= 4'h5)
		else $error("cycle count out of range"); // [RULE3]
	// every opcode with low nibble one is an absolute branch
	abs_three_a: assert property (@(posedge mclk) disable iff (!rst_ok_n) // [RULE6]
		fetch_strobe && opcode[3:0] == 4'h1 |-> ##12 instr_done)
		else $error("absolute branch not three cycles");
	// both returns restore the counter in four cycles
	ret_four_a: assert property (@(posedge mclk) disable iff (!rst_ok_n) // [RULE22]
		fetch_strobe && (opcode == cbt_pkg::OP_SUB_RETURN || opcode == cbt_pkg::OP_INT_RETURN)
		|-> ##16 instr_done) else $error("return not four cycles");
	// bit branch with clear
	bit_clear_a: assert property (@(posedge mclk) disable iff (!rst_ok_n) // [RULE9]
		fetch_strobe && opcode == cbt_pkg::OP_BIT_CLEAR |-> ##16 instr_done)
		else $error("bit branch not four cycles");
	// all four compare-and-branch forms
	cmp_four_a: assert property (@(posedge mclk) disable iff (!rst_ok_n) // [RULE11]
		fetch_strobe && (opcode == cbt_pkg::OP_CMP_DIRECT || opcode == cbt_pkg::OP_CMP_IMM
		|| opcode[7:3] == 5'b10111 || opcode[7:1] == 7'b1011011) |-> ##16 instr_done)
		else $error("compare branch not four cycles");
	// register form of decrement branch
	dec_reg_a: assert property (@(posedge mclk) disable iff (!rst_ok_n) // [RULE12]
		fetch_strobe && opcode[7:3] == 5'b11011 |-> ##12 instr_done)
		else $error("register decrement branch not three cycles");
	// direct form of decrement branch
	dec_direct_a: assert property (@(posedge mclk) disable iff (!rst_ok_n) // [RULE12]
		fetch_strobe && opcode == cbt_pkg::OP_DEC_DIRECT |-> ##16 instr_done)
		else $error("direct decrement branch not four cycles");
	// direct to direct byte move
	move_dir_a: assert property (@(posedge mclk) disable iff (!rst_ok_n) // [RULE4]
		fetch_strobe && opcode == cbt_pkg::OP_MOVE_DIR_DIR |-> ##12 instr_done)
		else $error("direct move not three cycles");
	// a queued opcode starts on the edge that ends the last one
	back_to_back_a: assert property (@(posedge mclk) disable iff (!rst_ok_n) // [RULE3]
		instr_done && opcode_valid |-> fetch_strobe)
		else $error("idle cycle between opcodes");
	// no opcode fetches more bytes than it has cycles
	bytes_le_a: assert property (@(posedge mclk) disable iff (!rst_ok_n) // [RULE5]
		fetch_strobe && !dec_xmove |-> {1'b0, dec_bytes} <= dec_cycles)
		else $error("more bytes than cycles");
	// fast timer ticks every fourth clock
	tick_fast_a: assert property (@(posedge mclk) disable iff (!rst_ok_n) // [RULE14]
		timer_tick && timer_fast |=> !timer_tick [*3] ##1 timer_tick)
		else $error("fast timer not four clocks");
	cov_pair: cover property (@(posedge mclk) disable iff (!rst_ok_n)
		instr_done && fetch_strobe);
	cov_ret: cover property (@(posedge mclk) disable iff (!rst_ok_n)
		fetch_strobe && opcode == cbt_pkg::OP_SUB_RETURN ##16 instr_done);
	cov_xmove: cover property (@(posedge mclk) disable iff (!rst_ok_n)
		fetch_strobe && dec_xmove && stretch_reg[2:0] == 3'h7);
	cov_sel: cover property (@(posedge mclk) disable iff (!rst_ok_n)
		sel_reg ##1 !sel_reg);
endmodule

// ---- design/cbt_decode.sv ----
`timescale 1ns/1ps
// opcode decoder: byte length, cycle count and class of each opcode
module cbt_decode (
	// opcode in
	input wire logic [7:0] opcode,
	input wire logic [2:0] stretch,
	// decode out
	output logic [1:0] byte_len,
	output logic [2:0] cycle_cnt,
	output logic is_xmove,
	output logic uses_ptr,
	output logic is_jump
);
	// ************************************************
	// table lookup
	// ************************************************
	always_comb begin
		byte_len = 2'h1;
		cycle_cnt = 3'h1;
		is_xmove = 1'b0;
		uses_ptr = 1'b0;
		is_jump = 1'b0;
		// one fetched byte per cycle unless listed below [RULE5]
		if (opcode == cbt_pkg::OP_NOP || opcode == cbt_pkg::OP_RESERVED_NOP) begin
			byte_len = 2'h1; // [RULE13]
			cycle_cnt = 3'h1;
		end else if (opcode[4:0] == 5'h11 || opcode[4:0] == 5'h01) begin
			byte_len = 2'h2; // [RULE6]
			cycle_cnt = 3'h3;
			is_jump = 1'b1;
		end else if (opcode == cbt_pkg::OP_LONG_CALL || opcode == cbt_pkg::OP_LONG_JUMP) begin
			byte_len = 2'h3; // [RULE7]
			cycle_cnt = 3'h4;
			is_jump = 1'b1;
		end else if (opcode == cbt_pkg::OP_SUB_RETURN || opcode == cbt_pkg::OP_INT_RETURN) begin
			byte_len = 2'h1; // [RULE22]
			cycle_cnt = 3'h4;
			is_jump = 1'b1;
		end else if (opcode == cbt_pkg::OP_SHORT_JUMP || opcode == cbt_pkg::OP_CARRY_JMP
				|| opcode == cbt_pkg::OP_NCARRY_JMP || opcode == cbt_pkg::OP_ZERO_JMP
				|| opcode == cbt_pkg::OP_NZERO_JMP || opcode[7:3] == 5'b11011) begin
			byte_len = 2'h2; // [RULE8] [RULE12]
			cycle_cnt = 3'h3;
			is_jump = 1'b1;
		end else if (opcode == cbt_pkg::OP_BIT_CLEAR || opcode == cbt_pkg::OP_BIT_SET_JMP
				|| opcode == cbt_pkg::OP_BIT_ZERO_JMP || opcode == cbt_pkg::OP_CMP_DIRECT
				|| opcode == cbt_pkg::OP_CMP_IMM || opcode[7:3] == 5'b10111
				|| opcode[7:1] == 7'b1011011 || opcode == cbt_pkg::OP_DEC_DIRECT) begin
			byte_len = 2'h3; // [RULE9] [RULE11] [RULE12]
			cycle_cnt = 3'h4;
			is_jump = 1'b1;
		end else if (opcode == cbt_pkg::OP_INDIRECT_JMP) begin
			byte_len = 2'h1; // [RULE10]
			cycle_cnt = 3'h3;
			uses_ptr = 1'b1;
			is_jump = 1'b1;
		end else if (opcode == cbt_pkg::OP_MOVE_DIR_DIR) begin
			byte_len = 2'h3; // [RULE4]
			cycle_cnt = 3'h3;
		end else if (opcode == cbt_pkg::OP_XREAD_PTR || opcode == cbt_pkg::OP_XWRITE_PTR
				|| opcode[7:1] == 7'b1110001 || opcode[7:1] == 7'b1111001) begin
			// only the stretch is reported; the sequencer adds the base pair [RULE1]
			is_xmove = 1'b1;
			uses_ptr = !opcode[1];
			byte_len = 2'h1;
			cycle_cnt = stretch;
		end
	end
endmodule

// ---- design/cbt_pkg.sv ----
// Overview of operation
// RULE1: external data move takes two plus stretch cycles
// RULE2: instruction cycle is four core clocks
// RULE3: instructions take one to five cycles
// RULE4: pointer read two cycles, direct move three
// RULE5: one code fetch per instruction byte; the core raises fetch_strobe once per opcode, whatever its byte count
// RULE6: absolute call and jump: two bytes, three cycles
// RULE7: long call and jump: three bytes, four cycles
// RULE8: short relative jump: two bytes, three cycles
// RULE9: bit branch and clear: three bytes, four cycles
// RULE10: indirect jump uses accumulator plus active pointer
// RULE11: compare branch: three bytes, four cycles
// RULE12: decrement branch: register three, direct four cycles
// RULE13: zero and reserved opcode are one-cycle no-ops
// RULE14: timer tick every twelve or four clocks
// RULE15: data pointer is sixteen bits wide
// RULE16: first pointer at low and high locations
// RULE17: second pointer at next two locations
// RULE18: select bit zero picks the active pointer
// RULE19: other select bits have no effect
// RULE20: software toggles select by incrementing it
// RULE21: pointers and select reset to zero
// RULE22: returns are one byte, four cycles
package cbt_pkg;
	// ************************************************
	// special function register locations
	// ************************************************
	localparam logic [7:0] ADDR_PTR_A_LOW = 8'h82;
	localparam logic [7:0] ADDR_PTR_A_HIGH = 8'h83;
	localparam logic [7:0] ADDR_PTR_B_LOW = 8'h84;
	localparam logic [7:0] ADDR_PTR_B_HIGH = 8'h85;
	localparam logic [7:0] ADDR_PTR_SELECT = 8'h86;
	localparam logic [7:0] ADDR_STRETCH = 8'h8E;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] STRETCH_RESET = 8'h01;
	localparam int SEL_BIT = 0;
	// ************************************************
	// timing
	// ************************************************
	localparam logic [1:0] CLKS_PER_CYCLE_M1 = 2'h3;
	localparam logic [3:0] TIMER_SLOW_M1 = 4'hB;
	localparam logic [3:0] TIMER_FAST_M1 = 4'h3;
	localparam logic [3:0] XMOVE_BASE = 4'h2;
	// ************************************************
	// opcodes
	// ************************************************
	localparam logic [7:0] OP_NOP = 8'h00;
	localparam logic [7:0] OP_RESERVED_NOP = 8'hA5;
	localparam logic [7:0] OP_LONG_JUMP = 8'h02;
	localparam logic [7:0] OP_LONG_CALL = 8'h12;
	localparam logic [7:0] OP_SUB_RETURN = 8'h22;
	localparam logic [7:0] OP_INT_RETURN = 8'h32;
	localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
	localparam logic [7:0] OP_BIT_CLEAR = 8'h10;
	localparam logic [7:0] OP_BIT_SET_JMP = 8'h20;
	localparam logic [7:0] OP_BIT_ZERO_JMP = 8'h30;
	localparam logic [7:0] OP_CARRY_JMP = 8'h40;
	localparam logic [7:0] OP_NCARRY_JMP = 8'h50;
	localparam logic [7:0] OP_ZERO_JMP = 8'h60;
	localparam logic [7:0] OP_NZERO_JMP = 8'h70;
	localparam logic [7:0] OP_INDIRECT_JMP = 8'h73;
	localparam logic [7:0] OP_CMP_DIRECT = 8'hB5;
	localparam logic [7:0] OP_CMP_IMM = 8'hB4;
	localparam logic [7:0] OP_DEC_DIRECT = 8'hD5;
	localparam logic [7:0] OP_MOVE_DIR_DIR = 8'h85;
	localparam logic [7:0] OP_XREAD_PTR = 8'hE0;
	localparam logic [7:0] OP_XWRITE_PTR = 8'hF0;
	localparam logic [7:0] OP_INC_DIRECT = 8'h05;
	// ************************************************
	// sequencer states
	// ************************************************
	typedef enum logic [1:0] {
		CBT_FETCH = 2'b00,
		CBT_EXEC = 2'b01,
		CBT_HALT = 2'b10
	} cbt_state_t;
endpackage

// ---- verif/cbt_prog_mem.sv ----
`timescale 1ns/1ps
// ************************************************
// program memory model
// ************************************************
// offers one opcode byte, withdraws it once the core takes it
module cbt_prog_mem (
	// clock
	input wire logic mclk,
	// load port from the bench
	input wire logic load,
	input wire logic [7:0] load_op,
	// core side
	input wire logic fetch_strobe,
	output logic [7:0] opcode,
	output logic opcode_valid
);
	// nothing offered before the bench asks
	initial begin
		opcode = 8'h00;
		opcode_valid = 1'b0;
	end
	// a taken byte shows its inverse so a second read is not a match
	always @(posedge mclk) begin
		if (fetch_strobe) begin
			opcode_valid <= 1'b0;
			opcode <= ~opcode;
		end else if (load) begin
			opcode_valid <= 1'b1;
			opcode <= load_op;
		end
	end
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
// ************************************************
// testbench
// ************************************************
module tb;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic load = 1'b0;
	logic [7:0] load_op = 8'h00;
	logic [7:0] acc = 8'h00;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic timer_fast = 1'b0;
	logic [7:0] opcode;
	logic opcode_valid, opcode_ready, fetch_strobe, cycle_strobe, timer_tick, instr_done;
	logic [7:0] sfr_rdata;
	logic [15:0] active_data_pointer, jump_target;
	int failures = 0;
	int n_compared = 0;
	// opcode table with cycle counts, stretch at reset value
	logic [7:0] op_tab [0:29] = '{8'h00, 8'hA5, 8'h11, 8'hF1, 8'h01, 8'hE1, 8'h12, 8'h02,
		8'h22, 8'h32, 8'h80, 8'h40, 8'h50, 8'h20, 8'h30, 8'h10, 8'h60, 8'h70, 8'hB5,
		8'hB4, 8'hB8, 8'hBF, 8'hB6, 8'hB7, 8'hD8, 8'hDF, 8'hD5, 8'h85, 8'hE0, 8'hF0};
	int cyc_tab [0:29] = '{1, 1, 3, 3, 3, 3, 4, 4, 4, 4, 3, 3, 3, 4, 4, 4, 3, 3, 4, 4, 4, 4,
		4, 4, 3, 3, 4, 3, 3, 3};
	// stretch settings: upper bits must not count
	logic [7:0] str_tab [0:2] = '{8'h05, 8'hF8, 8'h07};
	int str_cyc [0:2] = '{7, 2, 9};

	always #10 mclk = ~mclk;

	cbt_prog_mem mem_u (.mclk(mclk), .load(load), .load_op(load_op),
		.fetch_strobe(fetch_strobe), .opcode(opcode), .opcode_valid(opcode_valid));

	cbt_core dut_u (.mclk(mclk), .rst_n(rst_n), .opcode(opcode), .opcode_valid(opcode_valid),
		.opcode_ready(opcode_ready), .fetch_strobe(fetch_strobe), .acc(acc),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.timer_fast(timer_fast), .cycle_strobe(cycle_strobe), .timer_tick(timer_tick),
		.instr_done(instr_done), .active_data_pointer(active_data_pointer),
		.jump_target(jump_target));

	// ************************************************
	// compare and access tasks
	// ************************************************
	task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_cnt(input string what, input int exp, input int got);
		n_compared++;
		if (got != exp) begin
			failures++;
			$display("Error %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	// reset held five clocks, released just after an edge
	task automatic reset_dut();
		@(posedge mclk);
		#1 rst_n = 1'b0;
		repeat (5) @(posedge mclk);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge mclk);
	endtask
	task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge mclk);
		#1 sfr_addr = addr;
		sfr_wdata = data;
		sfr_wr = 1'b1;
		@(posedge mclk);
		#1 sfr_wr = 1'b0;
	endtask
	// read is combinational, looked at mid-cycle
	task automatic sfr_check(input logic [7:0] addr, input logic [7:0] exp);
		@(posedge mclk);
		#1 sfr_addr = addr;
		@(negedge mclk);
		chk_val($sformatf("sfr %h", addr), {8'h00, exp}, {8'h00, sfr_rdata});
	endtask
	// clocks from fetch edge to completion must be four per cycle
	task automatic run_op(input logic [7:0] op, input int cyc);
		int n;
		@(posedge mclk);
		#1 load = 1'b1;
		load_op = op;
		@(posedge mclk);
		#1 load = 1'b0;
		n = 0;
		do begin @(negedge mclk); n++; end while (fetch_strobe !== 1'b1 && n < 100);
		n = 0;
		do begin @(negedge mclk); n++; end while (instr_done !== 1'b1 && n < 60);
		chk_cnt($sformatf("clocks of opcode %h", op), 4 * cyc, n);
	endtask
	// opcode queued while another runs: taken on the edge that ends it
	task automatic run_pair(input logic [7:0] op);
		@(posedge mclk);
		#1 load = 1'b1;
		load_op = op;
		do begin @(negedge mclk); end while (fetch_strobe !== 1'b1);
		@(posedge mclk);
		#1 load_op = 8'h00;
		@(posedge mclk);
		#1 load = 1'b0;
		do begin @(negedge mclk); end while (instr_done !== 1'b1);
		chk_val("fetch on completion", 16'h0001, {15'h0000, fetch_strobe});
		do begin @(negedge mclk); end while (instr_done !== 1'b1);
	endtask
	// spacing between two pulses of the strobe or the timer tick
	task automatic pulse_gap(input bit tmr, input int exp, input string what);
		int n;
		n = 0;
		do begin @(negedge mclk); n++; end while ((tmr ? timer_tick : cycle_strobe) !== 1'b1 && n < 30);
		n = 0;
		do begin @(negedge mclk); n++; end while ((tmr ? timer_tick : cycle_strobe) !== 1'b1 && n < 30);
		chk_cnt(what, exp, n);
	endtask
	task automatic end_of_test();
		$display("Compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ************************************************
	// test sequence
	// ************************************************
	initial begin
		reset_dut();
		for (int a = 8'h82; a <= 8'h86; a++) sfr_check(a[7:0], 8'h00);
		sfr_check(8'h8E, 8'h01);
		sfr_check(8'h87, 8'h00);
		pulse_gap(1'b0, 4, "cycle strobe spacing");
		pulse_gap(1'b1, 12, "slow timer spacing");
		@(posedge mclk);
		#1 timer_fast = 1'b1;
		// let the prescaler settle on the new rate
		repeat (16) @(posedge mclk);
		pulse_gap(1'b1, 4, "fast timer spacing");
		for (int i = 0; i < 30; i++) run_op(op_tab[i], cyc_tab[i]);
		// the table also
		run_pair(8'h02);
		sfr_write(8'h82, 8'h34);
		sfr_write(8'h83, 8'h12);
		sfr_write(8'h84, 8'hCD);
		sfr_write(8'h85, 8'hAB);
		sfr_check(8'h83, 8'h12);
		sfr_check(8'h84, 8'hCD);
		chk_val("active pointer", 16'h1234, active_data_pointer);
		sfr_write(8'h86, 8'h01);
		sfr_check(8'h86, 8'h01);
		chk_val("active pointer", 16'hABCD, active_data_pointer);
		@(posedge mclk);
		#1 acc = 8'hF0;
		run_op(8'h73, 3);
		chk_val("jump target", 16'hACBD, jump_target);
		// software toggles the selection by writing the incremented value
		sfr_write(8'h86, 8'h02);
		sfr_check(8'h86, 8'h00);
		chk_val("active pointer", 16'h1234, active_data_pointer);
		sfr_write(8'h86, 8'hFE);
		run_op(8'h73, 3);
		chk_val("jump target", 16'h1324, jump_target);
		for (int i = 0; i < 3; i++) begin
			sfr_write(8'h8E, str_tab[i]);
			sfr_check(8'h8E, str_tab[i]);
			run_op(i == 1 ? 8'hE0 : 8'hF0, str_cyc[i]);
		end
		// short-address external read under the longest stretch
		run_op(8'hE2, 9);
		// a second reset in mid-run clears pointers and selection
		sfr_write(8'h86, 8'h01);
		reset_dut();
		sfr_check(8'h82, 8'h00);
		sfr_check(8'h85, 8'h00);
		sfr_check(8'h86, 8'h00);
		sfr_check(8'h8E, 8'h01);
		chk_val("active pointer", 16'h0000, active_data_pointer);
		end_of_test();
	end

	// watchdog well beyond the thousand or so clocks the tests need
	initial begin
		#200000;
		failures++;
		end_of_test();
	end
endmodule
